// file: include/io_router_map.svh
// Register offsets, field positions and reset values of the camera I/O line router.
// Assumes a 32-bit Avalon-MM slave with a byte address; offsets are byte addresses.
`ifndef IO_ROUTER_MAP_SVH
`define IO_ROUTER_MAP_SVH

`define REG_LINE_SELECT 8'h00
`define REG_LINE_SOURCE 8'h04
`define REG_LINE_INVERT 8'h08
`define REG_USER_OUT 8'h0C
`define REG_LINE_STATUS 8'h10
`define REG_LINE_STATUS_ALL 8'h14
`define REG_ACQ_CONFIG 8'h18
`define REG_TRIG_ASSIGN 8'h1C

`define SEL_WIDTH 3
`define SRC_WIDTH 3
`define SEL_RESET 3'h0
`define LINE_SELECT_FIRST_OUT 3'h2
`define INVERT_RESET 6'h00
`define USER_OUT_RESET 4'h0
`define TRIG_ASSIGN_RESET 2'h3
`define UNMAPPED_READ 32'h00000000

`endif

// file: include/io_router_pkg.sv
// Types shared by the camera I/O line router.
// Assumes nothing of its surroundings.
package io_router_pkg;
	typedef enum logic [2:0] {
		src_exposure_in_progress = 3'h0,
		src_next_trigger_allowed = 3'h1,
		src_acq_trigger_wait = 3'h2,
		src_timer = 3'h3,
		src_user = 3'h4
	} line_source_t;
	typedef enum logic {
		mode_standard = 1'b0,
		mode_legacy = 1'b1
	} acq_mode_t;
endpackage

// file: hw/camera_io_line_router.sv
// Camera I/O line router: two input lines, four output lines, Avalon-MM registers.
// Assumes mclk at 200 MHz, synchronous active-low rst_n, input pins asynchronous to mclk.
//
// Notes on behaviour
// - Four independent output lines, each driven from a selectable source.
// - Logic one turns the output transistor on, zero turns it off.
// - After reset output line 1 carries exposure in progress.
// - Exposure in progress is high exactly while the sensor exposes.
// - After reset output line 2 carries next trigger allowed.
// - Next trigger allowed rises at the earliest legal next exposure start.
// - Standard mode: input 1 feeds frame start, input 2 acquisition start.
// - Legacy mode: input 1 feeds acquisition start.
// - An unassigned input line is a user input readable by software.
// - An input line assigned as trigger is not a user input.
// - Per-line and all-lines status readback of input lines.
// - Each input line has its own inversion setting.
// - Sources: trigger wait, trigger allowed, exposure, timers; wait only in standard mode.
// - The user source drives the software-written level.
`timescale 1ns/10ps
`default_nettype none
`include "io_router_map.svh"

module camera_io_line_router #(
	parameter int IN_LINES = 2,
	parameter int OUT_LINES = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [IN_LINES-1:0] in_line_pin,
	input wire logic exposure_in_progress,
	input wire logic next_trigger_allowed,
	input wire logic acq_trigger_wait,
	input wire logic [OUT_LINES-1:0] timer_out,
	output logic [OUT_LINES-1:0] out_transistor_on,
	output logic frame_start_trigger,
	output logic acq_start_trigger
);

	////////////////////////////////////////////////////////////////////////////
	// Configuration state.

	logic [1:0] in_sync1;
	logic [1:0] in_sync2;
	logic [`SEL_WIDTH-1:0] line_select;
	io_router_pkg::line_source_t out_source [OUT_LINES];
	logic [5:0] line_invert;
	logic [3:0] user_out;
	io_router_pkg::acq_mode_t acq_mode;
	logic [1:0] trig_assign;
	logic [1:0] in_level;
	logic [1:0] user_in_level;
	logic access_done;
	logic [31:0] next_readdata;
	logic out_selected;
	logic [1:0] out_index;
	logic write_ok;

	// A write lands on the edge at which the master sees waitrequest low, never earlier.
	assign write_ok = avs_write && access_done && avs_byteenable[0];
	assign out_selected = line_select >= `LINE_SELECT_FIRST_OUT;
	assign out_index = 2'(line_select - `LINE_SELECT_FIRST_OUT);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and input routing.

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			in_sync1 <= 2'h0;
			in_sync2 <= 2'h0;
		end else begin
			in_sync1 <= in_line_pin[1:0];
			in_sync2 <= in_sync1;
		end
	end

	assign in_level = in_sync2 ^ line_invert[1:0];

	// trigger lines masked from user input
	assign user_in_level = in_level & ~trig_assign;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			frame_start_trigger <= 1'b0;
			acq_start_trigger <= 1'b0;
		end else if (acq_mode == io_router_pkg::mode_standard) begin
			frame_start_trigger <= trig_assign[0] & in_level[0];
			acq_start_trigger <= trig_assign[1] & in_level[1];
		end else begin
			frame_start_trigger <= 1'b0;
			acq_start_trigger <= trig_assign[0] & in_level[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output line sources.

	// one source multiplexer per output line
	genvar g;
	generate
		for (g = 0; g < OUT_LINES; g++) begin : g_out
			logic next_level;
			always_comb begin
				unique case (out_source[g])
					// internal status signals pass straight through
					io_router_pkg::src_exposure_in_progress: next_level = exposure_in_progress;
					io_router_pkg::src_next_trigger_allowed: next_level = next_trigger_allowed;
					// trigger wait only in standard mode
					io_router_pkg::src_acq_trigger_wait:
						next_level = acq_trigger_wait && acq_mode == io_router_pkg::mode_standard;
					io_router_pkg::src_timer: next_level = timer_out[g];
					io_router_pkg::src_user: next_level = user_out[g];
					default: next_level = 1'b0;
				endcase
			end
			// one means transistor conducting, inversion applied last
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					out_transistor_on[g] <= 1'b0;
				end else begin
					out_transistor_on[g] <= next_level ^ line_invert[g + 2];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Register writes.

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			line_select <= `SEL_RESET;
		end else if (write_ok && avs_address == `REG_LINE_SELECT) begin
			line_select <= avs_writedata[`SEL_WIDTH-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int i = 0; i < OUT_LINES; i++) begin
				out_source[i] <= io_router_pkg::src_user;
			end
			out_source[0] <= io_router_pkg::src_exposure_in_progress;
			out_source[1] <= io_router_pkg::src_next_trigger_allowed;
		end else if (write_ok && avs_address == `REG_LINE_SOURCE && out_selected
				&& avs_writedata[`SRC_WIDTH-1:0] <= 3'h4) begin
			out_source[out_index] <= io_router_pkg::line_source_t'(avs_writedata[`SRC_WIDTH-1:0]);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			line_invert <= `INVERT_RESET;
		end else if (write_ok && avs_address == `REG_LINE_INVERT && line_select <= 3'h5) begin
			line_invert[line_select] <= avs_writedata[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			user_out <= `USER_OUT_RESET;
		end else if (write_ok && avs_address == `REG_USER_OUT) begin
			user_out <= avs_writedata[3:0];
		end
	end

	// software picks which inputs are triggers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acq_mode <= io_router_pkg::mode_standard;
			trig_assign <= `TRIG_ASSIGN_RESET;
		end else if (write_ok && avs_address == `REG_ACQ_CONFIG) begin
			acq_mode <= io_router_pkg::acq_mode_t'(avs_writedata[0]);
		end else if (write_ok && avs_address == `REG_TRIG_ASSIGN) begin
			trig_assign <= avs_writedata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads and bus handshake.

	always_comb begin
		next_readdata = `UNMAPPED_READ;
		unique case (avs_address)
			`REG_LINE_SELECT: next_readdata[`SEL_WIDTH-1:0] = line_select;
			`REG_LINE_SOURCE: next_readdata[`SRC_WIDTH-1:0] = out_selected ? out_source[out_index] : 3'h0;
			`REG_LINE_INVERT: next_readdata[0] = line_select <= 3'h5 ? line_invert[line_select] : 1'b0;
			`REG_USER_OUT: next_readdata[3:0] = user_out;
			`REG_LINE_STATUS: next_readdata[0] = line_select < 3'h2 ? in_level[line_select[0]]
				: (out_selected && line_select <= 3'h5) ? out_transistor_on[out_index] : 1'b0;
			`REG_LINE_STATUS_ALL: next_readdata[7:0] = {user_in_level, out_transistor_on, in_level};
			`REG_ACQ_CONFIG: next_readdata[0] = acq_mode;
			`REG_TRIG_ASSIGN: next_readdata[1:0] = trig_assign;
			default: next_readdata = `UNMAPPED_READ;
		endcase
	end

	// One wait cycle per access; the answer comes on the second edge.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			access_done <= 1'b0;
			avs_readdata <= `UNMAPPED_READ;
		end else begin
			access_done <= (avs_read || avs_write) && !access_done;
			if (avs_read && !access_done) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !access_done;

endmodule // camera_io_line_router
`default_nettype wire

// file: test/io_far_end.sv
// External equipment on the input connector: drives the two input pins.
// Assumes the bench sets the wanted levels; the pins move off the core clock.
`timescale 1ns/10ps
`default_nettype none
module io_far_end (
	input wire logic [1:0] drive_level,
	output logic [1:0] in_line_pin
);
	// The equipment has no tie to the core clock, so edges land mid-period.
	assign #1.3 in_line_pin = drive_level;
endmodule // io_far_end
`default_nettype wire

// file: test/io_router_properties.sv
// Port assertions of the camera I/O line router.
// Assumes it is bound to the router and shares its clock and reset.
`timescale 1ns/10ps
`default_nettype none
module io_router_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic exposure_in_progress,
	input wire logic next_trigger_allowed,
	input wire logic [3:0] out_transistor_on
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic up;
	logic touched;
	// Defaults hold only until software writes anything.
	always_ff @(posedge mclk) begin
		up <= rst_n;
		touched <= rst_n && (touched || avs_write);
	end
	a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low on first request cycle");
	a_wait_one: assert property (avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
		else $error("more than one wait state");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest while idle");
	a_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("readdata moved without a read");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h20 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_out_reset: assert property ($rose(rst_n) |-> out_transistor_on == 4'h0)
		else $error("outputs not off after reset");
	a_line1_expo: assert property (up && !touched |-> out_transistor_on[0] == $past(exposure_in_progress))
		else $error("line 1 not following exposure");
	a_line2_trig: assert property (up && !touched |-> out_transistor_on[1] == $past(next_trigger_allowed))
		else $error("line 2 not following trigger allowed");
endmodule // io_router_chk
bind camera_io_line_router io_router_chk chk (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.exposure_in_progress(exposure_in_progress), .next_trigger_allowed(next_trigger_allowed),
	.out_transistor_on(out_transistor_on));
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the camera I/O line router.
// Assumes the register map header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "io_router_map.svh"
module tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] a = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdat;
	logic wt;
	logic [1:0] lvl = 2'h0;
	logic [1:0] pin;
	logic ex = 1'b0;
	logic ta = 1'b0;
	logic aw = 1'b0;
	logic [3:0] tm = 4'h0;
	logic [3:0] o;
	logic fst;
	logic ast;
	logic [31:0] got;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #2.5 mclk = ~mclk;
	camera_io_line_router DUT (.mclk(mclk), .rst_n(rst_n), .avs_address(a), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt), .in_line_pin(pin),
		.exposure_in_progress(ex), .next_trigger_allowed(ta), .acq_trigger_wait(aw), .timer_out(tm),
		.out_transistor_on(o), .frame_start_trigger(fst), .acq_start_trigger(ast));
	io_far_end far (.drive_level(lvl), .in_line_pin(pin));
	////////////////////////////////////////////////////////////////
	// Waitrequest and read data are taken at the edge itself, before that edge's updates land.
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge mclk);
		a <= ad;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge mclk);
		end while (wt !== 1'b0);
		got = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	// Two edges: one for the registered output to take a new value, one to sample it.
	task automatic step();
		repeat (2) @(posedge mclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pins(input logic [1:0] v);
		@(posedge mclk);
		lvl <= v;
		repeat (4) step();
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		ex <= 1'b1;
		step();
		chk("out defaults", 32'h1, o);
		@(posedge mclk);
		ex <= 1'b0;
		ta <= 1'b1;
		step();
		chk("out swapped", 32'h2, o);
		@(posedge mclk);
		ta <= 1'b0;
		tm <= 4'h5;
		$display("test defaults done");
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, `REG_LINE_SELECT, k + 2);
			xfer(1'b1, `REG_LINE_SOURCE, 32'h4);
			xfer(1'b1, `REG_USER_OUT, 32'h1 << k);
			step();
			chk("user out", 32'h1 << k, o);
		end
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, `REG_LINE_SELECT, k + 2);
			xfer(1'b1, `REG_LINE_SOURCE, 32'h3);
		end
		step();
		chk("timer", 32'h5, o);
		@(posedge mclk);
		tm <= 4'hA;
		aw <= 1'b1;
		xfer(1'b1, `REG_LINE_SELECT, 32'h2);
		xfer(1'b1, `REG_LINE_SOURCE, 32'h2);
		step();
		chk("wait standard", 32'hB, o);
		xfer(1'b1, `REG_ACQ_CONFIG, 32'h1);
		step();
		chk("wait legacy", 32'hA, o);
		xfer(1'b1, `REG_ACQ_CONFIG, 32'h0);
		$display("test outputs done");
		pins(2'h1);
		xfer(1'b0, `REG_LINE_STATUS_ALL, 32'h0);
		chk("status in", 32'h1, got[1:0]);
		chk("user in hidden", 32'h0, got[7:6]);
		chk("trig std 1", 32'h2, {fst, ast});
		pins(2'h2);
		chk("trig std 2", 32'h1, {fst, ast});
		xfer(1'b1, `REG_LINE_SELECT, 32'h0);
		xfer(1'b1, `REG_LINE_INVERT, 32'h1);
		repeat (4) step();
		xfer(1'b0, `REG_LINE_STATUS_ALL, 32'h0);
		chk("inverted", 32'h3, got[1:0]);
		chk("trig inverted", 32'h3, {fst, ast});
		xfer(1'b1, `REG_LINE_INVERT, 32'h0);
		xfer(1'b1, `REG_ACQ_CONFIG, 32'h1);
		pins(2'h1);
		chk("trig legacy", 32'h1, {fst, ast});
		xfer(1'b0, `REG_LINE_STATUS, 32'h0);
		chk("line status", 32'h1, got[0]);
		xfer(1'b1, `REG_TRIG_ASSIGN, 32'h0);
		pins(2'h3);
		xfer(1'b0, `REG_LINE_STATUS_ALL, 32'h0);
		chk("user in", 32'h3, got[7:6]);
		chk("no trig", 32'h0, {fst, ast});
		xfer(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, got);
		$display("test inputs done");
		final_report();
	end
	// Whole run is well under a thousand cycles; this only cuts a hang.
	initial begin
		#50000;
		n_mismatch++;
		final_report();
	end
endmodule // tb
`default_nettype wire
